// ### bench/acv_asserts.sv
`timescale 1ns/1ps
module acv_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acv_pkg::ADDR_W-1:0] paddr,
  input wire logic [acv_pkg::DATA_W-1:0] pwdata,
  input wire logic [acv_pkg::DATA_W-1:0] prdata,
  // Converter and pins
  input wire logic conv_enable,
  input wire logic conv_reset,
  input wire logic [2:0] conv_channel,
  input wire logic conv_clk,
  input wire logic [acv_pkg::CH_N-1:0] port_dir_in,
  input wire logic [acv_pkg::CH_N-1:0] port_dir_out,
  input wire logic [acv_pkg::CH_N-1:0] analog_pin_mask,
  input wire logic [acv_pkg::CH_N-1:0] pullup_disable,
  input wire logic irq
);
  import acv_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  wire wr_ctl = wr && paddr == OFF_CONTROL;
  wire wr_cp = wr && paddr == OFF_CLOCK_POWER;
  property p_all_pins;
    wr_ctl && pwdata[5:3] == 3'h7 |=> analog_pin_mask == 8'hff;
  endproperty
  a_all_pins: assert property (p_all_pins)
    else $error("all-analog pin code did not select all pins");
  property p_off;
    analog_pin_mask == 8'h00 |-> !conv_enable;
  endproperty
  a_off: assert property (p_off)
    else $error("converter on with no analog pins");
  property p_on;
    wr_cp && !pwdata[6] && analog_pin_mask != 8'h00 |=> conv_enable;
  endproperty
  a_on: assert property (p_on)
    else $error("converter not enabled");
  property p_pd;
    wr_cp && pwdata[6] |=> !conv_enable;
  endproperty
  a_pd: assert property (p_pd)
    else $error("converter on while powered down");
  property p_chan;
    wr_ctl |=> conv_channel == $past(pwdata[2:0]);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel select not routed");
  property p_rst;
    wr_ctl && pwdata[7] |=> conv_reset;
  endproperty
  a_rst: assert property (p_rst)
    else $error("start high did not hold converter in reset");
  property p_rst_clk;
    conv_reset [*3] |-> !conv_clk;
  endproperty
  a_rst_clk: assert property (p_rst_clk)
    else $error("converter clock runs during reset");
  property p_pins;
    pullup_disable == analog_pin_mask &&
      port_dir_out == (port_dir_in | analog_pin_mask);
  endproperty
  a_pins: assert property (p_pins)
    else $error("analog pins keep pull-up or direction");
  property p_mask;
    wr && paddr == OFF_IRQ_MASK && !pwdata[0] |=> !irq;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked interrupt still raised");
  property p_low;
    psel && !penable && !pwrite && paddr == OFF_RESULT_LOW |=>
      prdata[3:0] == 4'h0;
  endproperty
  a_low: assert property (p_low)
    else $error("unused low result bits not zero");
endmodule // acv_chk
bind acv_ctrl acv_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .conv_enable(conv_enable), .conv_reset(conv_reset),
  .conv_channel(conv_channel), .conv_clk(conv_clk),
  .port_dir_in(port_dir_in), .port_dir_out(port_dir_out),
  .analog_pin_mask(analog_pin_mask), .pullup_disable(pullup_disable),
  .irq(irq));

// ### bench/acv_core_model.sv
`timescale 1ns/1ps
module acv_core_model (
  // Clock
  input wire logic pclk,
  // Converter controls
  input wire logic conv_enable,
  input wire logic [2:0] conv_channel,
  // Sample
  output logic [acv_pkg::RES_W-1:0] conv_data
);
  import acv_pkg::*;
  logic [RES_W-1:0] junk = 12'h000;
  // Unpowered core gives no stable sample
  always @(posedge pclk) begin
    junk <= ~junk ^ 12'h001;
  end
  assign conv_data = conv_enable ? (12'h5a3 ^ {4{conv_channel}}) : junk;
endmodule // acv_core_model

// ### bench/test_adc_sequencing_control.sv
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module test_adc_sequencing_control;
  import acv_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00, pdi = 8'h0f, exp_m;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, c_en, c_rst, c_clk, irq;
  logic [2:0] c_ch;
  logic [11:0] c_data, exp_d;
  logic [7:0] pdo, amask, pud;
  int error_cnt = 0, n_tests = 0, cyc = 0, t0, h;
  initial forever #10 pclk = ~pclk;
  acv_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_enable(c_en), .conv_reset(c_rst), .conv_channel(c_ch),
    .conv_clk(c_clk), .conv_data(c_data), .port_dir_in(pdi),
    .port_dir_out(pdo), .analog_pin_mask(amask), .pullup_disable(pud),
    .irq(irq));
  acv_core_model core_u (.pclk(pclk), .conv_enable(c_en),
    .conv_channel(c_ch), .conv_data(c_data));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK(r, {24'h0, e}, "register read")
  endtask
  task automatic conv(input logic [2:0] sel, input logic [2:0] ch);
    h = sel == 3'h1 ? 4 : sel == 3'h2 ? 16 : 64;
    exp_d = 12'h5a3 ^ {4{ch}};
    apb(OFF_CLOCK_POWER, 1'b1, {29'h0, sel});
    apb(OFF_CONTROL, 1'b1, {24'h0, 5'h17, ch});
    @(negedge pclk);
    `CHK(c_rst, 1'b1, "start high not holding reset")
    rd(OFF_CONTROL, {5'h1f, ch});
    apb(OFF_CONTROL, 1'b1, {24'h0, 5'h07, ch});
    t0 = cyc;
    do apb(OFF_CONTROL, 1'b0, 32'h0); while (r[6] !== 1'b0);
    `CHK(cyc - t0 >= 32 * h && cyc - t0 <= 32 * h + 10, 1'b1, "duration")
    rd(OFF_RESULT_HIGH, exp_d[11:4]);
    rd(OFF_RESULT_LOW, {exp_d[3:0], 4'h0});
    rd(OFF_IRQ_STATUS, 8'h01);
    `CHK(irq, ch[0], "interrupt output")
    apb(OFF_IRQ_STATUS, 1'b1, 32'h1);
    @(negedge pclk);
    `CHK(irq, 1'b0, "interrupt not cleared")
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CONTROL, 8'h40);
    rd(OFF_CLOCK_POWER, 8'h40);
    rd(OFF_IRQ_MASK, 8'h00);
    apb(8'h18, 1'b0, 32'h0);
    `CHK(err, 1'b1, "unmapped address accepted")
    apb(OFF_RESULT_HIGH, 1'b1, 32'hff);
    rd(OFF_RESULT_HIGH, 8'h00);
    apb(OFF_CLOCK_POWER, 1'b1, 32'h1);
    for (int p = 0; p < 8; p++) begin
      exp_m = p == 7 ? 8'hff : (8'h01 << p) - 8'h01;
      apb(OFF_CONTROL, 1'b1, p << 3);
      @(negedge pclk);
      `CHK(amask, exp_m, "analog pin mask")
      `CHK(pud, exp_m, "pull-up disable")
      `CHK(pdo, exp_m | pdi, "port direction")
      `CHK(c_en, p != 0, "converter enable")
    end
    apb(OFF_CLOCK_POWER, 1'b1, 32'h41);
    @(negedge pclk);
    `CHK(c_en, 1'b0, "converter on while powered down")
    apb(OFF_CONTROL, 1'b1, 32'hb8);
    apb(OFF_CONTROL, 1'b1, 32'h38);
    repeat (200) @(posedge pclk);
    rd(OFF_CONTROL, 8'h78);
    apb(OFF_IRQ_MASK, 1'b1, 32'h1);
    for (int c = 0; c < 8; c++) begin
      apb(OFF_IRQ_MASK, 1'b1, c % 2);
      conv(3'h1, c[2:0]);
    end
    conv(3'h2, 3'h3);
    conv(3'h3, 3'h5);
    conv(3'h7, 3'h7);
    tally_and_finish();
  end
endmodule // test_adc_sequencing_control

// ### src/acv_clk_div.sv
`timescale 1ns/1ps
module acv_clk_div (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [2:0] clock_select,
  // Divided clock
  output logic conv_clk,
  output logic tick
);
  import acv_pkg::*;

  logic [HALF_W-1:0] half_cnt;
  logic half_end;

  assign half_end = (half_cnt == acv_div_half(clock_select) - 7'h01);

  // Half-period counter; restarts whenever the divider is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt <= '0;
    end else if (!run || half_end) begin
      half_cnt <= '0;
    end else begin
      half_cnt <= half_cnt + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_clk <= 1'b0;
    end else if (!run) begin
      conv_clk <= 1'b0;
    end else if (half_end) begin
      conv_clk <= !conv_clk; // [RULE11]
    end
  end

  // One pulse per completed converter clock period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
    end else begin
      tick <= run && half_end && conv_clk;
    end
  end

endmodule // acv_clk_div

// ### src/acv_ctrl.sv
`timescale 1ns/1ps
module acv_ctrl (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acv_pkg::ADDR_W-1:0] paddr,
  input wire logic [acv_pkg::DATA_W-1:0] pwdata,
  output logic [acv_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core
  output logic conv_enable,
  output logic conv_reset,
  output logic [2:0] conv_channel,
  output logic conv_clk,
  input wire logic [acv_pkg::RES_W-1:0] conv_data,
  // Shared port pins
  input wire logic [acv_pkg::CH_N-1:0] port_dir_in,
  output logic [acv_pkg::CH_N-1:0] port_dir_out,
  output logic [acv_pkg::CH_N-1:0] analog_pin_mask,
  output logic [acv_pkg::CH_N-1:0] pullup_disable,
  // Interrupt
  output logic irq
);
  import acv_pkg::*;

  // Bus phases
  logic setup_phase;
  logic access_phase;
  logic wr_en;

  // Software-visible state
  logic start_bit;
  logic end_of_conv_flag_n;
  logic [2:0] pin_config;
  logic [2:0] channel_select;
  logic conv_power_down;
  logic [2:0] clock_select;
  logic [RES_W-1:0] result;
  logic irq_status;
  logic irq_mask;

  // Sequencer
  acv_state_type state;
  acv_state_type next_state;
  logic [3:0] period_cnt;
  logic conv_tick;
  logic conv_done;
  logic conv_on;

  // Converter data synchroniser
  logic [RES_W-1:0] data_meta;
  logic [RES_W-1:0] data_sync;

  // Assembled register views
  logic [7:0] ctrl_view;
  logic [7:0] clkpwr_view;
  logic [7:0] result_low_view;
  logic [7:0] result_high_view;
  logic [DATA_W-1:0] next_prdata;

  //--------------------------------------------------------------------
  // APB decode
  //--------------------------------------------------------------------
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_en = access_phase && pwrite && acv_addr_ok(paddr);

  // Zero wait states; unmapped offsets answer with an error
  assign pready = access_phase;
  assign pslverr = access_phase && !acv_addr_ok(paddr);

  //--------------------------------------------------------------------
  // Control register: start, pin configuration, channel select
  //--------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_bit <= 1'b0;
    end else if (wr_en && paddr == OFF_CONTROL) begin
      start_bit <= pwdata[CTRL_START_BIT]; // [RULE7]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_config <= PCFG_RESET;
      channel_select <= CHSEL_RESET;
    end else if (wr_en && paddr == OFF_CONTROL) begin
      pin_config <= pwdata[CTRL_PCFG_LSB +: 3]; // [RULE4]
      channel_select <= pwdata[CTRL_CHSEL_LSB +: 3]; // [RULE3]
    end
  end

  //--------------------------------------------------------------------
  // Clock and power register
  //--------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_power_down <= PWRDN_RESET;
      clock_select <= CKSEL_RESET;
    end else if (wr_en && paddr == OFF_CLOCK_POWER) begin
      conv_power_down <= pwdata[CP_PWRDN_BIT];
      clock_select <= pwdata[CP_CKSEL_LSB +: 3]; // [RULE11]
    end
  end

  //--------------------------------------------------------------------
  // Converter power and pin ownership
  //--------------------------------------------------------------------
  // Off when pin configuration is zero or power-down is set
  assign conv_on = !conv_power_down && (pin_config != 3'h0); // [RULE5] [RULE6]
  assign conv_enable = conv_on; // [RULE6]
  assign conv_channel = channel_select; // [RULE1] [RULE3]
  assign conv_reset = start_bit; // [RULE8]

  assign analog_pin_mask = acv_pin_mask(pin_config); // [RULE4] [RULE5]
  assign pullup_disable = analog_pin_mask; // [RULE15]
  // Port direction: one means input; analog pins are forced to input
  assign port_dir_out = port_dir_in | analog_pin_mask; // [RULE15]

  //--------------------------------------------------------------------
  // Converter clock divider
  //--------------------------------------------------------------------
  acv_clk_div u_clk_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(state == ST_CONV),
    .clock_select(clock_select),
    .conv_clk(conv_clk),
    .tick(conv_tick)
  );

  //--------------------------------------------------------------------
  // Conversion sequencer
  //--------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_bit) begin
          next_state = ST_RESET; // [RULE8]
        end
      end
      ST_RESET: begin
        // Falling edge of start completes the pulse
        if (!start_bit) begin
          next_state = conv_on ? ST_CONV : ST_IDLE; // [RULE7]
        end
      end
      ST_CONV: begin
        if (start_bit) begin
          next_state = ST_RESET; // [RULE8]
        end else if (!conv_on) begin
          next_state = ST_IDLE; // [RULE6]
        end else if (conv_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counts converter clock periods within a conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_cnt <= '0;
    end else if (state != ST_CONV) begin
      period_cnt <= '0;
    end else if (conv_tick) begin
      period_cnt <= period_cnt + 4'h1; // [RULE13]
    end
  end

  assign conv_done = (state == ST_CONV) && !start_bit && conv_on &&
                     conv_tick && (period_cnt == CONV_LAST); // [RULE13]

  //--------------------------------------------------------------------
  // End-of-conversion flag
  //--------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_of_conv_flag_n <= EOC_RESET;
    end else if (start_bit) begin
      end_of_conv_flag_n <= 1'b1; // [RULE8]
    end else if (conv_done) begin
      end_of_conv_flag_n <= 1'b0; // [RULE9]
    end
  end

  //--------------------------------------------------------------------
  // Result capture
  //--------------------------------------------------------------------
  // Core data arrives from the analog domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      data_meta <= conv_data;
      data_sync <= data_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= RESULT_RESET;
    end else if (conv_done) begin
      result <= data_sync; // [RULE1] [RULE16]
    end
  end

  //--------------------------------------------------------------------
  // Interrupt status and mask
  //--------------------------------------------------------------------
  // Completion wins over a simultaneous write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 1'b0;
    end else if (conv_done) begin
      irq_status <= 1'b1; // [RULE10]
    end else if (wr_en && paddr == OFF_IRQ_STATUS &&
                 pwdata[IRQ_DONE_BIT]) begin
      irq_status <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= 1'b0;
    end else if (wr_en && paddr == OFF_IRQ_MASK) begin
      irq_mask <= pwdata[IRQ_DONE_BIT];
    end
  end

  assign irq = irq_status && irq_mask; // [RULE10]

  //--------------------------------------------------------------------
  // Read path
  //--------------------------------------------------------------------
  always_comb begin
    ctrl_view = '0;
    ctrl_view[CTRL_START_BIT] = start_bit;
    ctrl_view[CTRL_EOC_BIT] = end_of_conv_flag_n; // [RULE9]
    ctrl_view[CTRL_PCFG_LSB +: 3] = pin_config;
    ctrl_view[CTRL_CHSEL_LSB +: 3] = channel_select;
  end

  always_comb begin
    clkpwr_view = '0;
    clkpwr_view[CP_PWRDN_BIT] = conv_power_down;
    clkpwr_view[CP_CKSEL_LSB +: 3] = clock_select;
  end

  // Result split over two bytes; unused low nibble reads zero
  assign result_high_view = result[11:4]; // [RULE2]
  assign result_low_view = {result[3:0], 4'h0}; // [RULE2] [RULE17]

  always_comb begin
    next_prdata = '0;
    case (paddr)
      OFF_RESULT_LOW: next_prdata[7:0] = result_low_view;
      OFF_RESULT_HIGH: next_prdata[7:0] = result_high_view;
      OFF_CONTROL: next_prdata[7:0] = ctrl_view;
      OFF_CLOCK_POWER: next_prdata[7:0] = clkpwr_view;
      OFF_IRQ_STATUS: next_prdata[IRQ_DONE_BIT] = irq_status;
      OFF_IRQ_MASK: next_prdata[IRQ_DONE_BIT] = irq_mask;
      default: next_prdata = '0;
    endcase
  end

  // Read data captured in the setup cycle and held through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Result offsets are never written: wr_en reaches them but no register decodes them [RULE17]

endmodule // acv_ctrl

// ### src/acv_pkg.sv
// Notes on behaviour
// RULE1 - One converter serves eight selectable inputs, each result twelve bits unsigned.
// RULE2 - High result byte holds bits 11..4; low byte bits 7..4 hold bits 3..0.
// RULE3 - Three-bit channel select field routes one of eight inputs to the converter.
// RULE4 - Three-bit pin configuration picks analog pins; value 111 makes all eight analog.
// RULE5 - Pin configuration zero leaves all pins digital and powers the converter down.
// RULE6 - Converter runs only with power-down bit 0 and nonzero pin configuration.
// RULE7 - Start bit driven low, high, low starts exactly one conversion.
// RULE8 - While start is high, converter held in reset and end flag forced to 1.
// RULE9 - End flag clears to 0 when conversion completes and stays readable.
// RULE10 - Completion sets the interrupt flag; interrupt output only when enabled.
// RULE11 - Converter clock is system clock divided per three-bit clock select field.
// RULE12 - Software should avoid clock select 000 above 4 MHz system clock.
// RULE13 - A conversion lasts sixteen converter clock periods from start pulse to flag clear.
// RULE14 - After changing channel select, software pulses start before trusting end flag.
// RULE15 - Analog pins lose their pull-ups and override the port direction control.
// RULE16 - Result registers load when the end flag clears and hold until next completion.
// RULE17 - Result register writes are ignored; low result byte bits 3..0 read zero.
package acv_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W = 12;
  localparam int CH_N = 8;
  localparam int HALF_W = 7;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_RESULT_LOW = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RESULT_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_POWER = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;

  // conv_control fields
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_EOC_BIT = 6;
  localparam int CTRL_PCFG_LSB = 3;
  localparam int CTRL_CHSEL_LSB = 0;

  // conv_clock_power fields
  localparam int CP_PWRDN_BIT = 6;
  localparam int CP_CKSEL_LSB = 0;

  // Interrupt status and mask fields
  localparam int IRQ_DONE_BIT = 0;

  // Values after reset
  localparam logic [2:0] CHSEL_RESET = 3'h0;
  localparam logic [2:0] PCFG_RESET = 3'h0;
  localparam logic [2:0] CKSEL_RESET = 3'h0;
  localparam logic PWRDN_RESET = 1'b1;
  localparam logic EOC_RESET = 1'b1;
  localparam logic [RES_W-1:0] RESULT_RESET = 12'h000;
  localparam logic [7:0] PIN_MASK_ALL = 8'hff;

  // Conversion length in converter clock periods, and last index
  localparam logic [4:0] CONV_PERIODS = 5'h10;
  localparam logic [3:0] CONV_LAST = 4'hf;

  // Half periods of the converter clock in pclk cycles per clock select
  localparam logic [HALF_W-1:0] HALF_DIV2 = 7'h01;
  localparam logic [HALF_W-1:0] HALF_DIV8 = 7'h04;
  localparam logic [HALF_W-1:0] HALF_DIV32 = 7'h10;
  localparam logic [HALF_W-1:0] HALF_DIV128 = 7'h40;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESET = 2'b01,
    ST_CONV = 2'b10
  } acv_state_type;

  // Pin configuration to analog pin mask: n selects the lowest n pins, and 7 selects all eight
  function automatic logic [7:0] acv_pin_mask(input logic [2:0] cfg);
    logic [7:0] m;
    m = 8'h00;
    if (cfg == 3'h7) begin
      m = PIN_MASK_ALL;
    end else if (cfg != 3'h0) begin
      m = (8'h01 << cfg) - 8'h01;
    end
    return m;
  endfunction

  // Clock select code to half period in pclk cycles
  function automatic logic [HALF_W-1:0] acv_div_half(input logic [2:0] sel);
    logic [HALF_W-1:0] h;
    case (sel)
      3'h0: h = HALF_DIV2;
      3'h1: h = HALF_DIV8;
      3'h2: h = HALF_DIV32;
      default: h = HALF_DIV128;
    endcase
    return h;
  endfunction

  function automatic logic acv_addr_ok(input logic [ADDR_W-1:0] a);
    return (a == OFF_RESULT_LOW) || (a == OFF_RESULT_HIGH) ||
           (a == OFF_CONTROL) || (a == OFF_CLOCK_POWER) ||
           (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_MASK);
  endfunction

endpackage
